// File: src/csr_bank.sv
// Purpose : core status, indirect select, port data and control register bank
// Assumes : pins already synchronised inside here; one register access per clock
// Notes   : alu and instruction events are single-cycle pulses from the core
`default_nettype none

module csr_bank
  import csr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       alu_upd_carry,
  input  wire logic       alu_carry,
  input  wire logic       alu_nibble_carry,
  input  wire logic       alu_upd_zero,
  input  wire logic       alu_zero,
  input  wire logic       instr_sleep,
  input  wire logic       instr_wdt_clear,
  input  wire logic       wdt_timeout,
  input  wire logic       ext_irq_edge_sel,
  input  wire logic       ev_timer0_ovf,
  input  wire logic       ev_port_change,
  input  wire logic       ev_timer1_udf,
  input  wire logic [3:0] pin_port_a,
  input  wire logic [7:0] pin_port_b,
  output logic      [3:0] port_a_latch,
  output logic      [7:0] port_b_latch,
  output logic      [7:0] indirect_addr,
  output logic      [1:0] pc_high_bits,
  output logic            lvr_detect_en,
  output logic            watchdog_run,
  output logic            ext_irq_active,
  output logic      [7:0] wake_pin_en,
  output logic            wake_request,
  output logic            crystal_speedup_stop,
  output logic      [7:0] pull_low_en,
  output logic      [7:0] pull_high_en,
  output logic      [7:0] irq_pending
);

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] status_q;
  logic [7:0] indsel_q;
  logic [3:0] port_a_data_spare_q;
  logic [7:0] pwrctl_q;
  logic [7:0] wakeen_q;
  logic [2:0] program_counter_high_buffer_q;
  logic [7:0] pulllo_q;
  logic [7:0] pullhi_q;
  logic [7:0] irqen_q;
  logic [7:0] irqflg_q;
  logic       xstop_q;
  logic [3:0] pa_s1_q;
  logic [3:0] pa_s2_q;
  logic [7:0] pb_s1_q;
  logic [7:0] pb_s2_q;
  logic       pb0_prev_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pa_s1_q <= 4'h0;
      pa_s2_q <= 4'h0;
      pb_s1_q <= 8'h00;
      pb_s2_q <= 8'h00;
    end
    else
    begin
      pa_s1_q <= pin_port_a;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= pin_port_b;
      pb_s2_q <= pb_s1_q;
    end
  end

  // ****************************************
  // status register
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      status_q <= CSR_RST_STATUS;
    else
    begin
      // a firmware write loses to a same-cycle hardware event
      if (reg_wr && hit(reg_addr, CSR_OFS_STATUS))
        status_q <= reg_wdata;
      if (alu_upd_carry)
      begin
        status_q[CSR_ST_CARRY]  <= alu_carry;
        status_q[CSR_ST_NIBBLE] <= alu_nibble_carry;
      end
      if (alu_upd_zero)
        status_q[CSR_ST_ZERO] <= alu_zero;
      if (instr_wdt_clear)
      begin
        status_q[CSR_ST_SLEEPN] <= 1'b1;
        status_q[CSR_ST_WDTN]   <= 1'b1;
      end
      else if (instr_sleep)
      begin
        status_q[CSR_ST_SLEEPN] <= 1'b0;
        status_q[CSR_ST_WDTN]   <= 1'b1;
      end
      if (wdt_timeout)
        status_q[CSR_ST_WDTN] <= 1'b0;
    end
  end

  // ****************************************
  // indirect select
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      indsel_q <= CSR_RST_INDSEL;
    else if (reg_wr && hit(reg_addr, CSR_OFS_INDSEL))
      indsel_q <= reg_wdata;
  end

  // ****************************************
  // port output latches
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      port_a_latch  <= CSR_RST_PORT_A_DATA;
      port_a_data_spare_q <= CSR_RST_PORT_A_DATA;
      port_b_latch  <= CSR_RST_PORT_B_DATA;
    end
    else
    begin
      if (reg_wr && hit(reg_addr, CSR_OFS_PORT_A_DATA))
      begin
        port_a_latch  <= reg_wdata[3:0];
        port_a_data_spare_q <= reg_wdata[7:4];
      end
      if (reg_wr && hit(reg_addr, CSR_OFS_PORT_B_DATA))
        port_b_latch <= reg_wdata;
    end
  end

  // ****************************************
  // power control and wake enables
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pwrctl_q <= CSR_RST_PWRCTL;
      wakeen_q <= CSR_RST_WAKEEN;
    end
    else
    begin
      if (reg_wr && hit(reg_addr, CSR_OFS_PWRCTL))
        pwrctl_q <= reg_wdata;
      if (reg_wr && hit(reg_addr, CSR_OFS_WAKEEN))
        wakeen_q <= reg_wdata;
    end
  end

  // ****************************************
  // program counter high buffer
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      program_counter_high_buffer_q <= CSR_RST_PROGRAM_COUNTER_HIGH_BUFFER;
    else if (reg_wr && hit(reg_addr, CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER))
      program_counter_high_buffer_q <= reg_wdata[2:0];
  end

  // ****************************************
  // pull resistor controls
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pulllo_q <= CSR_RST_PULLLO;
      pullhi_q <= CSR_RST_PULLHI;
    end
    else
    begin
      if (reg_wr && hit(reg_addr, CSR_OFS_PULLLO))
        pulllo_q <= reg_wdata;
      if (reg_wr && hit(reg_addr, CSR_OFS_PULLHI))
        pullhi_q <= reg_wdata;
    end
  end

  // ****************************************
  // interrupt enable mask
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqen_q <= CSR_RST_IRQEN;
    else if (reg_wr && hit(reg_addr, CSR_OFS_IRQEN))
      irqen_q <= reg_wdata & CSR_IRQ_MASK;
  end

  // ****************************************
  // crystal speed-up stop, sticky once written
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      xstop_q <= 1'b0;
    else if (reg_wr && hit(reg_addr, CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER) && reg_wdata[CSR_PH_XSTOP])
      xstop_q <= 1'b1;
  end

  // ****************************************
  // interrupt pending flags
  // ****************************************
  logic       pb0_rise;
  logic       pb0_fall;
  logic       ext_edge;
  logic [7:0] irq_set;

  assign pb0_rise = pb_s2_q[0] && !pb0_prev_q;
  assign pb0_fall = !pb_s2_q[0] && pb0_prev_q;
  assign ext_edge = pwrctl_q[CSR_PC_EIS] &&
                    (ext_irq_edge_sel ? pb0_rise : pb0_fall);

  always_comb
  begin
    irq_set = 8'h00;
    irq_set[CSR_IRQ_T0]  = ev_timer0_ovf;
    irq_set[CSR_IRQ_PB]  = ev_port_change;
    irq_set[CSR_IRQ_EXT] = ext_edge;
    irq_set[CSR_IRQ_T1]  = ev_timer1_udf;
    irq_set[CSR_IRQ_WDT] = wdt_timeout;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irqflg_q   <= 8'h00;
      pb0_prev_q <= 1'b0;
    end
    else
    begin
      pb0_prev_q <= pb_s2_q[0];
      // set wins over a firmware clear in the same cycle
      if (reg_wr && hit(reg_addr, CSR_OFS_IRQFLG))
        irqflg_q <= ((reg_wdata & irqflg_q) | irq_set) & CSR_IRQ_MASK;
      else
        irqflg_q <= (irqflg_q | irq_set) & CSR_IRQ_MASK;
    end
  end

  // ****************************************
  // port B wake-up qualification
  // ****************************************
  // a pin wakes the core only on a change while its enable bit is set
  logic [7:0]      pb_prev_q;
  wire logic [7:0] wake_hit;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pb_prev_q <= 8'h00;
    else
      pb_prev_q <= pb_s2_q;
  end

  for (genvar gi = 0; gi < 8; gi++)
  begin : g_wake
    assign wake_hit[gi] = wakeen_q[gi] && (pb_s2_q[gi] != pb_prev_q[gi]);
  end

  // ****************************************
  // control outputs
  // ****************************************
  assign indirect_addr        = indsel_q;
  assign pc_high_bits         = program_counter_high_buffer_q[1:0];
  assign lvr_detect_en        = pwrctl_q[CSR_PC_LOW_VOLTAGE_RESET_ENABLE];
  assign watchdog_run         = pwrctl_q[CSR_PC_WATCHDOG_ENABLE_BIT];
  assign ext_irq_active       = pwrctl_q[CSR_PC_EIS];
  assign wake_pin_en          = wakeen_q;
  assign wake_request         = |wake_hit;
  assign crystal_speedup_stop = xstop_q;
  assign pull_low_en          = ~pulllo_q;
  assign pull_high_en         = ~pullhi_q;
  assign irq_pending          = irqflg_q & irqen_q;

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    reg_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        CSR_OFS_STATUS: reg_rdata = status_q;
        CSR_OFS_INDSEL: reg_rdata = indsel_q;
        CSR_OFS_PORT_A_DATA:  reg_rdata = {port_a_data_spare_q, pa_s2_q};
        CSR_OFS_PORT_B_DATA:  reg_rdata = pb_s2_q;
        CSR_OFS_PWRCTL: reg_rdata = pwrctl_q;
        CSR_OFS_WAKEEN: reg_rdata = wakeen_q;
        CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER: reg_rdata = {5'h00, program_counter_high_buffer_q}; // write-only bit reads zero
        CSR_OFS_PULLLO: reg_rdata = pulllo_q;
        CSR_OFS_PULLHI: reg_rdata = pullhi_q;
        CSR_OFS_IRQEN:  reg_rdata = irqen_q;
        CSR_OFS_IRQFLG: reg_rdata = irqflg_q & irqen_q;
        default:        reg_rdata = 8'h00;
      endcase
    end
  end

endmodule : csr_bank

`default_nettype wire

// File: common/csr_pkg.sv
// Purpose : constants for the core status and port control register bank
// Assumes : 8-bit register file access, one access per instruction clock
// Notes   : offsets are register file addresses within the R-page window
`default_nettype none

package csr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] CSR_OFS_STATUS  = 4'h3;
  localparam logic [3:0] CSR_OFS_INDSEL  = 4'h4;
  localparam logic [3:0] CSR_OFS_PORT_A_DATA   = 4'h5;
  localparam logic [3:0] CSR_OFS_PORT_B_DATA   = 4'h6;
  localparam logic [3:0] CSR_OFS_PWRCTL  = 4'h8;
  localparam logic [3:0] CSR_OFS_WAKEEN  = 4'h9;
  localparam logic [3:0] CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER  = 4'hA;
  localparam logic [3:0] CSR_OFS_PULLLO  = 4'hB;
  localparam logic [3:0] CSR_OFS_PULLHI  = 4'hC;
  localparam logic [3:0] CSR_OFS_IRQEN   = 4'hE;
  localparam logic [3:0] CSR_OFS_IRQFLG  = 4'hF;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CSR_ST_CARRY  = 0;
  localparam int CSR_ST_NIBBLE = 1;
  localparam int CSR_ST_ZERO   = 2;
  localparam int CSR_ST_SLEEPN = 3;
  localparam int CSR_ST_WDTN   = 4;
  localparam int CSR_PC_LOW_VOLTAGE_RESET_ENABLE  = 3;
  localparam int CSR_PC_EIS    = 6;
  localparam int CSR_PC_WATCHDOG_ENABLE_BIT  = 7;
  localparam int CSR_PH_XSTOP  = 6;
  localparam int CSR_PH_GP5    = 2;
  localparam int CSR_IRQ_T0    = 0;
  localparam int CSR_IRQ_PB    = 1;
  localparam int CSR_IRQ_EXT   = 2;
  localparam int CSR_IRQ_T1    = 3;
  localparam int CSR_IRQ_WDT   = 6;

  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [7:0] CSR_RST_STATUS = 8'h18;
  localparam logic [7:0] CSR_RST_INDSEL = 8'h00;
  localparam logic [7:0] CSR_RST_PWRCTL = 8'h88;
  localparam logic [7:0] CSR_RST_WAKEEN = 8'hFF;
  localparam logic [2:0] CSR_RST_PROGRAM_COUNTER_HIGH_BUFFER = 3'h0;
  localparam logic [7:0] CSR_RST_PULLLO = 8'hFF;
  localparam logic [7:0] CSR_RST_PULLHI = 8'hFF;
  localparam logic [7:0] CSR_RST_IRQEN  = 8'h00;
  localparam logic [7:0] CSR_IRQ_MASK   = 8'h4F;
  localparam logic [3:0] CSR_RST_PORT_A_DATA  = 4'h0;
  localparam logic [7:0] CSR_RST_PORT_B_DATA  = 8'h00;

endpackage : csr_pkg

`default_nettype wire

// File: test/csr_bank_sva.sv
// Purpose : assertion checker for the core status and port control bank
// Assumes : one clock, asynchronous active-high reset
// Notes   : pin reads lag two clocks behind the pins, through the synchroniser
`default_nettype none
module csr_bank_sva
  import csr_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       alu_upd_carry,
  input wire logic       alu_carry,
  input wire logic       alu_nibble_carry,
  input wire logic       alu_upd_zero,
  input wire logic       alu_zero,
  input wire logic       instr_sleep,
  input wire logic       instr_wdt_clear,
  input wire logic       wdt_timeout,
  input wire logic [3:0] pin_port_a,
  input wire logic [7:0] pin_port_b,
  input wire logic [7:0] indirect_addr,
  input wire logic [7:0] irq_pending
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // synchroniser holds reset values for a while, so pin checks wait
  logic [1:0] up_q;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  wire logic st_rd = reg_rd && reg_addr == CSR_OFS_STATUS;
  sequence s_pa; $stable(pin_port_a) [*3]; endsequence
  sequence s_pb; $stable(pin_port_b) [*3]; endsequence
  // expected low status bits: a write, then alu updates, then instruction events, then a timeout win
  logic [4:0] st_q;
  logic [4:0] st_d;
  always_comb
  begin
    st_d = st_q;
    if (reg_wr && reg_addr == CSR_OFS_STATUS)
      st_d = reg_wdata[4:0];
    if (alu_upd_carry)
      st_d[1:0] = {alu_nibble_carry, alu_carry};
    if (alu_upd_zero)
      st_d[2] = alu_zero;
    if (instr_wdt_clear)
      st_d[4:3] = 2'h3;
    else if (instr_sleep)
      st_d[4:3] = 2'h2;
    if (wdt_timeout)
      st_d[4] = 1'b0;
  end
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) st_q <= CSR_RST_STATUS[4:0];
    else st_q <= st_d;
  property p_carry; st_rd |-> reg_rdata[1:0] == st_q[1:0]; endproperty
  a_carry: assert property (p_carry) else $error("carry flags wrong");
  property p_zero; st_rd |-> reg_rdata[2] == st_q[2]; endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_sleep; st_rd |-> reg_rdata[3] == st_q[3]; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flag wrong");
  property p_wdt; st_rd |-> reg_rdata[4] == st_q[4]; endproperty
  a_wdt: assert property (p_wdt) else $error("timeout flag wrong");
  property p_pa;
    s_pa ##0 (up_q == 2'h3 && reg_rd && reg_addr == CSR_OFS_PORT_A_DATA) |-> reg_rdata[3:0] == pin_port_a;
  endproperty
  a_pa: assert property (p_pa) else $error("port a read not pins");
  property p_pb;
    s_pb ##0 (up_q == 2'h3 && reg_rd && reg_addr == CSR_OFS_PORT_B_DATA) |-> reg_rdata == pin_port_b;
  endproperty
  a_pb: assert property (p_pb) else $error("port b read not pins");
  property p_ind;
    reg_wr && reg_addr == CSR_OFS_INDSEL |=> indirect_addr == $past(reg_wdata);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect address wrong");
  property p_irq; reg_rd && reg_addr == CSR_OFS_IRQFLG |-> reg_rdata == irq_pending; endproperty
  a_irq: assert property (p_irq) else $error("flag read not masked");
  property p_mask;
    reg_wr && reg_addr == CSR_OFS_IRQEN && reg_wdata == 8'h00 |=> irq_pending == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("masked flag pending");
endmodule : csr_bank_sva
`default_nettype wire

// File: test/test_csr_bank.sv
// Purpose : self-checking bench for the core status and port control bank
// Assumes : inputs move on the falling edge; read data is combinational
// Notes   : pins settle five cycles before a read, past the synchroniser
`default_nettype none
module test_csr_bank
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, alu_upd_carry = 1'b0;
  logic alu_carry = 1'b0, alu_nibble_carry = 1'b0, alu_upd_zero = 1'b0, alu_zero = 1'b0;
  logic instr_sleep = 1'b0, instr_wdt_clear = 1'b0, wdt_timeout = 1'b0, ext_irq_edge_sel = 1'b0;
  logic ev_timer0_ovf = 1'b0, ev_port_change = 1'b0, ev_timer1_udf = 1'b0;
  logic [3:0] reg_addr = 4'h0, pin_port_a = 4'h0, port_a_latch;
  logic [7:0] reg_wdata = 8'h00, pin_port_b = 8'h00, reg_rdata, port_b_latch, indirect_addr;
  logic [7:0] wake_pin_en, pull_low_en, pull_high_en, irq_pending;
  logic [1:0] pc_high_bits;
  logic lvr_detect_en, watchdog_run, ext_irq_active, wake_request, crystal_speedup_stop;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  csr_bank DUT (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .alu_upd_carry, .alu_carry, .alu_nibble_carry, .alu_upd_zero, .alu_zero, .instr_sleep,
    .instr_wdt_clear, .wdt_timeout, .ext_irq_edge_sel, .ev_timer0_ovf, .ev_port_change,
    .ev_timer1_udf, .pin_port_a, .pin_port_b, .port_a_latch, .port_b_latch, .indirect_addr,
    .pc_high_bits, .lvr_detect_en, .watchdog_run, .ext_irq_active, .wake_pin_en, .wake_request,
    .crystal_speedup_stop, .pull_low_en, .pull_high_en, .irq_pending);
  always #5 clk_sys = ~clk_sys;
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rc(string nm, logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    #1 chk(nm, reg_rdata & m, e);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask : rc
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_status;
    rc("status rst", CSR_OFS_STATUS, 8'h18, 8'h18);
    alu_carry = 1'b1;
    pulse(alu_upd_carry);
    rc("carry", CSR_OFS_STATUS, 8'h03, 8'h01);
    alu_carry = 1'b0;
    alu_nibble_carry = 1'b1;
    pulse(alu_upd_carry);
    rc("nibble", CSR_OFS_STATUS, 8'h03, 8'h02);
    alu_zero = 1'b1;
    pulse(alu_upd_zero);
    rc("zero", CSR_OFS_STATUS, 8'h04, 8'h04);
    alu_zero = 1'b0;
    pulse(alu_upd_zero);
    rc("nonzero", CSR_OFS_STATUS, 8'h04, 8'h00);
    wr(CSR_OFS_STATUS, 8'hE0);
    rc("spare", CSR_OFS_STATUS, 8'hE0, 8'hE0);
    pulse(instr_sleep);
    rc("sleep", CSR_OFS_STATUS, 8'h18, 8'h10);
    pulse(wdt_timeout);
    rc("timeout", CSR_OFS_STATUS, 8'h18, 8'h00);
    pulse(instr_wdt_clear);
    rc("clear", CSR_OFS_STATUS, 8'h18, 8'h18);
    $display("test status done");
  endtask : t_status
  task automatic t_regs;
    rc("pwr rst", CSR_OFS_PWRCTL, 8'hFF, 8'h88);
    rc("wake rst", CSR_OFS_WAKEEN, 8'hFF, 8'hFF);
    rc("pch rst", CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER, 8'h03, 8'h00);
    rc("plo rst", CSR_OFS_PULLLO, 8'hFF, 8'hFF);
    rc("phi rst", CSR_OFS_PULLHI, 8'hFF, 8'hFF);
    rc("ien rst", CSR_OFS_IRQEN, CSR_IRQ_MASK, 8'h00);
    rc("bank rst", CSR_OFS_INDSEL, 8'hC0, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(CSR_OFS_INDSEL, {i[1:0], 6'h3F});
      chk("bank", indirect_addr, {i[1:0], 6'h3F});
    end
    wr(CSR_OFS_PWRCTL, 8'h77);
    chk("pwr out", {5'h0, watchdog_run, ext_irq_active, lvr_detect_en}, 8'h02);
    rc("pwr rd", CSR_OFS_PWRCTL, 8'hFF, 8'h77);
    wr(CSR_OFS_WAKEEN, 8'h5A);
    chk("wake", wake_pin_en, 8'h5A);
    wr(CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER, 8'h02);
    chk("pch", {5'h0, crystal_speedup_stop, pc_high_bits}, 8'h02);
    wr(CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER, 8'h47);
    chk("xstop", {5'h0, crystal_speedup_stop, pc_high_bits}, 8'h07);
    rc("pch rd", CSR_OFS_PROGRAM_COUNTER_HIGH_BUFFER, 8'h07, 8'h07);
    wr(CSR_OFS_PULLLO, 8'h3C);
    chk("plo", pull_low_en, 8'hC3);
    wr(CSR_OFS_PULLHI, 8'h3A);
    chk("phi", pull_high_en, 8'hC5);
    wr(4'h7, 8'hFF);
    rc("unmapped", 4'h7, 8'hFF, 8'h00);
    $display("test registers done");
  endtask : t_regs
  task automatic wake_to(logic [7:0] p, logic [7:0] e);
    logic [7:0] hits;
    hits = 8'h00;
    pin_port_b = p;
    repeat (4)
    begin
      @(negedge clk_sys);
      hits = hits + {7'h00, wake_request};
    end
    chk("wake req", hits, e);
  endtask : wake_to
  task automatic t_ports;
    pin_port_a = 4'hA;
    pin_port_b = 8'h96;
    wr(CSR_OFS_PORT_A_DATA, 8'h05);
    wr(CSR_OFS_PORT_B_DATA, 8'h69);
    chk("latch a", {4'h0, port_a_latch}, 8'h05);
    chk("latch b", port_b_latch, 8'h69);
    rc("pins a", CSR_OFS_PORT_A_DATA, 8'h0F, 8'h0A);
    rc("pins b", CSR_OFS_PORT_B_DATA, 8'hFF, 8'h96);
    wr(CSR_OFS_WAKEEN, 8'h0F);
    wake_to(8'h06, 8'h00);
    wake_to(8'h02, 8'h01);
    wake_to(8'h96, 8'h01);
    $display("test ports done");
  endtask : t_ports
  task automatic edge_to(logic [7:0] p, logic [7:0] e);
    wr(CSR_OFS_IRQFLG, 8'h00);
    pin_port_b = p;
    repeat (4) @(negedge clk_sys);
    rc("ext flag", CSR_OFS_IRQFLG, 8'hFF, e);
  endtask : edge_to
  task automatic t_irq;
    wr(CSR_OFS_IRQEN, 8'h00);
    wr(CSR_OFS_IRQFLG, 8'h00);
    ev_timer0_ovf = 1'b1;
    ev_port_change = 1'b1;
    ev_timer1_udf = 1'b1;
    @(negedge clk_sys);
    ev_timer0_ovf = 1'b0;
    ev_port_change = 1'b0;
    ev_timer1_udf = 1'b0;
    rc("masked", CSR_OFS_IRQFLG, 8'hFF, 8'h00);
    wr(CSR_OFS_IRQEN, 8'hFF);
    rc("ien", CSR_OFS_IRQEN, CSR_IRQ_MASK, CSR_IRQ_MASK);
    rc("flags", CSR_OFS_IRQFLG, 8'hFF, 8'h0B);
    wr(CSR_OFS_IRQFLG, 8'hF6);
    rc("clr", CSR_OFS_IRQFLG, 8'hFF, 8'h02);
    wr(CSR_OFS_PWRCTL, 8'hC8);
    ext_irq_edge_sel = 1'b1;
    edge_to(8'h97, 8'h04);
    ext_irq_edge_sel = 1'b0;
    edge_to(8'h96, 8'h04);
    edge_to(8'h97, 8'h00);
    wr(CSR_OFS_PWRCTL, 8'h88);
    edge_to(8'h96, 8'h00);
    $display("test interrupts done");
  endtask : t_irq
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    t_status();
    t_regs();
    t_ports();
    t_irq();
    test_done();
  end
endmodule : test_csr_bank
bind csr_bank csr_bank_sva u_sva (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .alu_upd_carry, .alu_carry, .alu_nibble_carry, .alu_upd_zero, .alu_zero,
  .instr_sleep, .instr_wdt_clear, .wdt_timeout, .pin_port_a, .pin_port_b, .indirect_addr,
  .irq_pending);
`default_nettype wire
